/* common/sccrc_pkg.sv */
// Constants and types for the subsector cyclic code and parity block
package sccrc_pkg;

    localparam int          CODE_BITS      = 16;
    localparam int          DATA_WORDS     = 16;
    localparam int          WORD_BITS      = 16;
    localparam logic [15:0] CODE_POLY_DEF  = 16'h8005;
    localparam logic [15:0] CODE_RESET     = 16'h0000;
    localparam logic [3:0]  BIT_COUNT_LAST = 4'hf;
    localparam int          ERR_BIT_POS    = 15;
    localparam int          CLOCK_KHZ      = 125000;
    localparam int          SUPPLY_GOOD_MS = 100;
    localparam int          SUPPLY_GOOD_CYCLES = SUPPLY_GOOD_MS * CLOCK_KHZ;

    typedef enum logic [1:0] {
        SCCRC_IDLE   = 2'b00,
        SCCRC_DATA   = 2'b01,
        SCCRC_CODE   = 2'b11,
        SCCRC_PARITY = 2'b10
    } sccrc_phase_type;

endpackage

/* dv/sccrc_check_checker.sv */
// Port assertions for the subsector code and parity block
`timescale 1ns/100ps
module sccrc_check_checker (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        init_pulse,
    input wire logic        supply_ok,
    input wire logic        subsector_start,
    input wire logic        write_shift_strobe,
    input wire logic        read_shift_strobe,
    input wire logic        read_addr_legal,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] error_bits,
    input wire logic        write_data_n,
    input wire logic        disc_write_n,
    input wire logic        disc_read_n,
    input wire logic        read_check_error
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_err_rise;
        !read_check_error ##1 read_check_error;
    endsequence
    sequence s_err_held;
        read_check_error && !init_pulse;
    endsequence
    a_err_strobe: assert property (
        s_err_rise |-> $past(read_shift_strobe))
        else $error("error flag rose without a read strobe");
    a_err_sticky: assert property (
        s_err_held |=> read_check_error)
        else $error("error flag dropped without initialize");
    a_err_bit15: assert property (
        error_bits[15] == $past(read_check_error))
        else $error("error bit 15 does not follow the flag");
    a_gate_init: assert property (
        init_pulse |=> disc_write_n)
        else $error("write gate not cleared by initialize");
    a_supply_drop: assert property (
        !supply_ok |-> ##[1:2] disc_write_n)
        else $error("write gate active on bad supply");
    a_read_legal: assert property (
        !read_addr_legal [*2] |-> disc_read_n)
        else $error("read line driven on illegal address");
    a_wdata_clock: assert property (
        $changed(write_data_n) |->
        $past(write_shift_strobe || init_pulse || subsector_start))
        else $error("write data moved without a write strobe");
    a_rdata_idle: assert property (
        !$past(reg_read) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
endmodule

bind sccrc_check sccrc_check_checker u_chk (
    .clock(clock), .nrst(nrst), .init_pulse(init_pulse),
    .supply_ok(supply_ok), .subsector_start(subsector_start),
    .write_shift_strobe(write_shift_strobe),
    .read_shift_strobe(read_shift_strobe),
    .read_addr_legal(read_addr_legal), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .error_bits(error_bits),
    .write_data_n(write_data_n), .disc_write_n(disc_write_n),
    .disc_read_n(disc_read_n), .read_check_error(read_check_error));

/* dv/sccrc_check_tb.sv */
// Self-checking bench for the subsector code and parity block
`timescale 1ns/100ps
module sccrc_check_tb;
    localparam int GOOD = 20;
    logic        clock, nrst, init_pulse, supply_ok, subsector_start;
    logic        write_req, read_req, read_addr_legal, reg_write, reg_read;
    logic        wss, rss, shift_out_bit, read_data, go, rd_mode, slow;
    logic        write_data_n, disc_write_n, disc_read_n, read_check_error;
    logic        irq, busy, data_bad, gate_seen, read_seen;
    logic [8:0]  req_address, flip_a, flip_b, ones_count;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic [15:0] error_bits;
    int          num_errors, check_count;

    sccrc_check #(.GOOD_CYCLES(GOOD)) dut (
        .clock(clock), .nrst(nrst), .init_pulse(init_pulse),
        .supply_ok(supply_ok), .subsector_start(subsector_start),
        .write_req(write_req), .read_req(read_req),
        .req_address(req_address), .location_count(9'h005),
        .read_addr_legal(read_addr_legal), .write_shift_strobe(wss),
        .read_shift_strobe(rss), .shift_out_bit(shift_out_bit),
        .read_data(read_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .error_bits(error_bits), .write_data_n(write_data_n),
        .disc_write_n(disc_write_n), .disc_read_n(disc_read_n),
        .read_check_error(read_check_error), .irq(irq));
    sccrc_drive_model drive (
        .clock(clock), .go(go), .rd_mode(rd_mode), .slow(slow),
        .flip_a(flip_a), .flip_b(flip_b), .word(16'ha5c3),
        .write_data_n(write_data_n), .write_shift_strobe(wss),
        .read_shift_strobe(rss), .read_data(read_data),
        .shift_out_bit(shift_out_bit), .busy(busy),
        .ones_count(ones_count), .data_bad(data_bad));

    always #4 clock = ~clock;
    always @(posedge clock) begin
        if (disc_write_n === 1'b0) begin
            gate_seen <= 1'b1;
        end
        if (disc_read_n === 1'b0) begin
            read_seen <= 1'b1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic sub(input logic rm, input logic [8:0] adr,
                       input logic [8:0] fa, input logic [8:0] fb,
                       input logic sl);
        int n;
        @(negedge clock);
        {gate_seen, read_seen} = 2'b00;
        @(posedge clock);
        subsector_start <= 1'b1;
        go <= 1'b1;
        write_req <= !rm;
        read_req <= rm;
        rd_mode <= rm;
        req_address <= adr;
        flip_a <= fa;
        flip_b <= fb;
        slow <= sl;
        @(posedge clock);
        subsector_start <= 1'b0;
        go <= 1'b0;
        n = 0;
        while (n < 3000 && (n < 2 || busy)) begin
            @(posedge clock);
            n++;
        end
        if (n == 3000) begin
            num_errors++;
            end_of_test();
        end
        repeat (3) @(posedge clock);
        #1;
    endtask

    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        init_pulse = 1'b0;
        supply_ok = 1'b1;
        subsector_start = 1'b0;
        write_req = 1'b0;
        read_req = 1'b0;
        read_addr_legal = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 32'h0000_0000;
        reg_wdata = 32'h0000_0000;
        req_address = 9'h000;
        {go, rd_mode, slow, gate_seen, read_seen} = 5'h00;
        {flip_a, flip_b} = {9'h1ff, 9'h1ff};
        num_errors = 0;
        check_count = 0;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1 chk(32'({write_data_n, disc_write_n, disc_read_n,
                    read_check_error, irq}), 32'h0000_001c);
        rd(32'h0000_0000, 32'h0000_0000);
        rd(32'h0000_0008, 32'h0000_0000);
        rd(32'h0000_000c, 32'h0000_0000);
        wr(32'h0000_0004, 32'h0000_0003);
        rd(32'h0000_0004, 32'h0000_0003);
        wr(32'h0000_0004, 32'h0000_0000);
        repeat (GOOD + 10) @(posedge clock);
        rd(32'h0000_0008, 32'h0000_0040);
        sub(1'b0, 9'h005, 9'h1ff, 9'h1ff, 1'b0);
        chk(32'(data_bad), 32'h0000_0000);
        chk(32'(ones_count[0]), 32'h0000_0001);
        chk(32'(gate_seen), 32'h0000_0001);
        sub(1'b1, 9'h005, 9'h1ff, 9'h1ff, 1'b1);
        chk(32'(read_check_error), 32'h0000_0000);
        chk(32'(read_seen), 32'h0000_0001);
        sub(1'b1, 9'h005, 9'h025, 9'h1ff, 1'b0);
        chk(32'(read_check_error), 32'h0000_0001);
        chk(32'(error_bits), 32'h0000_8000);
        chk(32'(irq), 32'h0000_0000);
        rd(32'h0000_0000, 32'h0000_0003);
        wr(32'h0000_0004, 32'h0000_0003);
        repeat (3) @(posedge clock);
        #1 chk(32'(irq), 32'h0000_0001);
        wr(32'h0000_0000, 32'h0000_0001);
        rd(32'h0000_0000, 32'h0000_0002);
        wr(32'h0000_0000, 32'h0000_0002);
        rd(32'h0000_0000, 32'h0000_0000);
        #1 chk(32'(irq), 32'h0000_0000);
        // A clean subsector must not clear a standing error
        sub(1'b1, 9'h005, 9'h1ff, 9'h1ff, 1'b0);
        chk(32'(read_check_error), 32'h0000_0001);
        @(posedge clock);
        init_pulse <= 1'b1;
        @(posedge clock);
        init_pulse <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk(32'({read_check_error, error_bits}), 32'h0000_0000);
        chk(32'(disc_write_n), 32'h0000_0001);
        @(posedge clock);
        read_addr_legal <= 1'b0;
        sub(1'b1, 9'h005, 9'h110, 9'h1ff, 1'b0);
        chk(32'(read_seen), 32'h0000_0000);
        rd(32'h0000_0000, 32'h0000_0002);
        wr(32'h0000_0000, 32'h0000_0003);
        read_addr_legal <= 1'b1;
        sub(1'b1, 9'h005, 9'h102, 9'h103, 1'b0);
        rd(32'h0000_0000, 32'h0000_0001);
        sub(1'b0, 9'h006, 9'h1ff, 9'h1ff, 1'b0);
        chk(32'(gate_seen), 32'h0000_0000);
        @(posedge clock);
        supply_ok <= 1'b0;
        sub(1'b0, 9'h005, 9'h1ff, 9'h1ff, 1'b0);
        chk(32'(gate_seen), 32'h0000_0000);
        end_of_test();
    end
endmodule

/* dv/sccrc_drive_model.sv */
// Behavioural drive: bit strobes, captures written bits, replays reads
`timescale 1ns/100ps
module sccrc_drive_model (
    input  wire logic        clock,
    input  wire logic        go,
    input  wire logic        rd_mode,
    input  wire logic        slow,
    input  wire logic [8:0]  flip_a,
    input  wire logic [8:0]  flip_b,
    input  wire logic [15:0] word,
    input  wire logic        write_data_n,
    output logic             write_shift_strobe,
    output logic             read_shift_strobe,
    output logic             read_data,
    output logic             shift_out_bit,
    output logic             busy,
    output logic [8:0]       ones_count,
    output logic             data_bad
);
    localparam int TOTAL = 273;
    logic stored [TOTAL];
    logic bit_v;
    initial begin
        write_shift_strobe = 1'b0;
        read_shift_strobe = 1'b0;
        read_data = 1'b0;
        shift_out_bit = 1'b0;
        busy = 1'b0;
        ones_count = 9'h000;
        data_bad = 1'b0;
        forever begin
            @(posedge clock);
            if (go) begin
                busy <= 1'b1;
                if (!rd_mode) begin
                    ones_count = 9'h000;
                    data_bad = 1'b0;
                end
                for (int i = 0; i < TOTAL; i++) begin
                    bit_v = word[15 - (i % 16)] ^ i[4];
                    if (rd_mode) begin
                        bit_v = stored[i] ^ (i == flip_a) ^ (i == flip_b);
                    end
                    if (slow) begin
                        repeat (4) @(posedge clock);
                    end
                    read_shift_strobe <= rd_mode;
                    // Write bit clock runs in reads too: it loads the
                    // read line flip-flop
                    write_shift_strobe <= 1'b1;
                    read_data <= bit_v;
                    shift_out_bit <= bit_v;
                    @(posedge clock);
                    read_shift_strobe <= 1'b0;
                    write_shift_strobe <= 1'b0;
                    // Released lines show the inverse, not a stale bit
                    read_data <= ~bit_v;
                    shift_out_bit <= ~bit_v;
                    @(posedge clock);
                    if (!rd_mode) begin
                        stored[i] = ~write_data_n;
                        ones_count = ones_count + 9'(stored[i]);
                        if (i < 256 && stored[i] !== bit_v) begin
                            data_bad = 1'b1;
                        end
                    end
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

/* rtl/sccrc_check.sv */
// Subsector cyclic code, parity and disc signalling logic
`timescale 1ns/100ps
module sccrc_check #(
    parameter logic [15:0] CODE_POLY   = sccrc_pkg::CODE_POLY_DEF,
    parameter int          GOOD_CYCLES = sccrc_pkg::SUPPLY_GOOD_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        init_pulse,
    input  wire logic        supply_ok,
    input  wire logic        subsector_start,
    input  wire logic        write_req,
    input  wire logic        read_req,
    input  wire logic [8:0]  req_address,
    input  wire logic [8:0]  location_count,
    input  wire logic        read_addr_legal,
    input  wire logic        write_shift_strobe,
    input  wire logic        read_shift_strobe,
    input  wire logic        shift_out_bit,
    input  wire logic        read_data,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    output logic [15:0]      error_bits,
    output logic             write_data_n,
    output logic             disc_write_n,
    output logic             disc_read_n,
    output logic             read_check_error,
    output logic             irq
);
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0000;
    localparam logic [31:0] MASK_ADDR   = 32'h0000_0004;
    localparam logic [31:0] STATE_ADDR  = 32'h0000_0008;

    sccrc_pkg::sccrc_phase_type phase_r;
    logic        write_sector_latch;
    logic        read_sector_latch;
    logic        sector_match;
    logic [3:0]  bit_cnt_r;
    logic [3:0]  word_cnt_r;
    logic        parity_toggle_ff;
    logic        code_word_cycle;
    logic        parity_bit_cycle;
    logic        code_last_stage;
    logic        code_residue_nonzero;
    logic        bit_count_last;
    logic        shift;
    logic        serial_in;
    logic        clear_code;
    logic        write_ok;
    logic        disc_read_r;
    logic        code_err_set;
    logic        par_err_set;
    logic [1:0]  status_r;
    logic [1:0]  mask_r;
    logic [1:0]  status_set;
    logic [1:0]  status_clr;
    logic        par_with_bit;
    logic        code_shift;
    logic        code_feed;
    logic        arm_write;
    logic        arm_read;
    logic        wr_status;
    logic        wr_mask;
    logic        gate_load;

    // One address compare shared by the status and mask register writes
    function automatic logic reg_hit(input logic [31:0] addr,
                                     input logic [31:0] base);
        return addr == base;
    endfunction

    // Address equality arms the transfer
    assign sector_match   = (req_address == location_count);
    assign code_word_cycle  = (phase_r == sccrc_pkg::SCCRC_CODE);
    assign parity_bit_cycle = (phase_r == sccrc_pkg::SCCRC_PARITY);
    assign bit_count_last = (bit_cnt_r == sccrc_pkg::BIT_COUNT_LAST);
    assign clear_code     = subsector_start | init_pulse;

    // Write strobe drives a write, read strobe drives a read
    assign shift = write_sector_latch ? write_shift_strobe
                 : read_sector_latch & read_shift_strobe;
    assign serial_in = write_sector_latch
                     ? (code_word_cycle ? code_last_stage : shift_out_bit)
                     : read_data;

    assign code_err_set = read_sector_latch & code_word_cycle
                        & bit_count_last & code_residue_nonzero
                        & read_shift_strobe;
    // Parity ff preset to one ends at zero on an odd total, so fold in
    // the parity bit on the line before judging it
    assign par_with_bit = parity_toggle_ff ^ read_data;
    assign par_err_set  = read_sector_latch & parity_bit_cycle
                        & par_with_bit & read_shift_strobe;

    // Code register holds still in the parity cycle; in the write code
    // cycle feedback is off so the stored word shifts straight out
    assign code_shift = shift & !parity_bit_cycle;
    assign code_feed  = !(write_sector_latch & code_word_cycle);

    // Latches arm on a matched request; write also needs good supply
    assign arm_write = write_req & sector_match & write_ok;
    assign arm_read  = read_req & !write_req & sector_match;

    sccrc_code_gen #(
        .POLY (CODE_POLY)
    ) u_code (
        .clock                (clock),
        .nrst                 (nrst),
        .clear                (clear_code),
        .shift                (code_shift),
        .feed_back            (code_feed),
        .serial_in            (serial_in),
        .code_last_stage      (code_last_stage),
        .code_residue_nonzero (code_residue_nonzero)
    );

    sccrc_supply_guard #(
        .GOOD_CYCLES (GOOD_CYCLES)
    ) u_guard (
        .clock        (clock),
        .nrst         (nrst),
        .supply_ok    (supply_ok),
        .write_enable (write_ok)
    );

    // Write latch: armed at subsector start, dropped after the parity bit
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            write_sector_latch <= 1'b0;
        end else if (init_pulse) begin
            write_sector_latch <= 1'b0;
        end else if (subsector_start) begin
            write_sector_latch <= arm_write;
        end else if (parity_bit_cycle && shift) begin
            write_sector_latch <= 1'b0;
        end else if (!write_ok) begin
            write_sector_latch <= 1'b0;
        end
    end

    // Read latch: same life span, no supply condition
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            read_sector_latch <= 1'b0;
        end else if (init_pulse) begin
            read_sector_latch <= 1'b0;
        end else if (subsector_start) begin
            read_sector_latch <= arm_read;
        end else if (parity_bit_cycle && shift) begin
            read_sector_latch <= 1'b0;
        end
    end

    // Phase and bit/word counting over 16 words, code, then parity
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase_r    <= sccrc_pkg::SCCRC_IDLE;
            bit_cnt_r  <= 4'h0;
            word_cnt_r <= 4'h0;
        end else if (init_pulse) begin
            phase_r    <= sccrc_pkg::SCCRC_IDLE;
            bit_cnt_r  <= 4'h0;
            word_cnt_r <= 4'h0;
        end else if (subsector_start) begin
            phase_r    <= sccrc_pkg::SCCRC_DATA;
            bit_cnt_r  <= 4'h0;
            word_cnt_r <= 4'h0;
        end else if (shift) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            unique case (phase_r)
                sccrc_pkg::SCCRC_IDLE: begin
                    bit_cnt_r <= 4'h0;
                end
                sccrc_pkg::SCCRC_DATA: begin
                    if (bit_count_last) begin
                        word_cnt_r <= word_cnt_r + 4'h1;
                        if (word_cnt_r == 4'hf) begin
                            phase_r <= sccrc_pkg::SCCRC_CODE;
                        end
                    end
                end
                sccrc_pkg::SCCRC_CODE: begin
                    if (bit_count_last) begin
                        phase_r <= sccrc_pkg::SCCRC_PARITY;
                    end
                end
                sccrc_pkg::SCCRC_PARITY: begin
                    phase_r <= sccrc_pkg::SCCRC_IDLE;
                end
            endcase
        end
    end

    // Parity preset at subsector start; toggles on each serial one, in the parity cycle on reads only
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            parity_toggle_ff <= 1'b1;
        end else if (clear_code) begin
            parity_toggle_ff <= 1'b1;
        end else if (shift && !parity_bit_cycle && serial_in) begin
            parity_toggle_ff <= !parity_toggle_ff;
        end else if (shift && parity_bit_cycle && read_data
                     && read_sector_latch) begin
            parity_toggle_ff <= !parity_toggle_ff;
        end
    end

    // Sticky error flag: only reset or initialize clears it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            read_check_error <= 1'b0;
        end else if (init_pulse) begin
            read_check_error <= 1'b0;
        end else if (!read_check_error) begin
            read_check_error <= code_err_set | par_err_set;
        end
    end

    // Serial write data on the write bit clock
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            write_data_n <= 1'b1;
        end else if (write_sector_latch && write_shift_strobe) begin
            unique case (phase_r)
                sccrc_pkg::SCCRC_CODE:
                    write_data_n <= !code_last_stage;
                sccrc_pkg::SCCRC_PARITY:
                    // Cleared parity ff means ones so far odd: write 0
                    write_data_n <= !parity_toggle_ff;
                default:
                    write_data_n <= !shift_out_bit;
            endcase
        end
    end

    // Gate follows the write latch on each write strobe and clears as
    // soon as the latch drops, so it never lingers into a read
    assign gate_load = write_shift_strobe | !write_sector_latch;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            disc_write_n <= 1'b1;
        end else if (init_pulse || !write_ok) begin
            disc_write_n <= 1'b1;
        end else if (gate_load) begin
            disc_write_n <= !write_sector_latch;
        end
    end

    // Read flip-flop loads on the write bit clock
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            disc_read_r <= 1'b0;
        end else if (init_pulse) begin
            disc_read_r <= 1'b0;
        end else if (write_shift_strobe) begin
            disc_read_r <= read_sector_latch;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            disc_read_n <= 1'b1;
        end else begin
            disc_read_n <= !(disc_read_r & read_addr_legal);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            error_bits <= 16'h0000;
        end else begin
            error_bits <= {read_check_error, 15'h0000};
        end
    end

    // Level interrupt from any unmasked sticky status bit
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    // Status: bit0 code error, bit1 parity error; each mismatch counts
    // even while the error flag already stands, and a set beats a clear
    assign wr_status  = reg_write & reg_hit(reg_addr, STATUS_ADDR);
    assign wr_mask    = reg_write & reg_hit(reg_addr, MASK_ADDR);
    assign status_set = {par_err_set, code_err_set};
    assign status_clr = wr_status ? reg_wdata[1:0] : 2'b00;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status_r <= 2'b00;
        end else begin
            status_r <= (status_r & ~status_clr) | status_set;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mask_r <= 2'b00;
        end else if (wr_mask) begin
            mask_r <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                STATUS_ADDR: reg_rdata <= {30'h0000_0000, status_r};
                MASK_ADDR:   reg_rdata <= {30'h0000_0000, mask_r};
                STATE_ADDR:  reg_rdata <= {24'h00_0000, read_check_error,
                                           write_ok, phase_r, bit_cnt_r};
                default:     reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

/* rtl/sccrc_code_gen.sv */
// Serial cyclic code generator with residue check
`timescale 1ns/100ps
module sccrc_code_gen #(
    parameter logic [15:0] POLY = sccrc_pkg::CODE_POLY_DEF
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        clear,
    input  wire logic        shift,
    input  wire logic        feed_back,
    input  wire logic        serial_in,
    output logic             code_last_stage,
    output logic             code_residue_nonzero
);
    logic [15:0] code_r;
    logic [15:0] code_nxt;
    logic        fb_bit;

    // Feedback gated off in the write code cycle so register just shifts out
    assign fb_bit   = feed_back & (serial_in ^ code_r[15]);
    assign code_nxt = {code_r[14:0], 1'b0} ^ (fb_bit ? POLY : 16'h0000);
    assign code_last_stage      = code_r[15];
    // Residue as it stands once the bit on the line is taken in, so the
    // last code strobe judges the whole word
    assign code_residue_nonzero = |code_nxt;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            code_r <= sccrc_pkg::CODE_RESET;
        end else if (clear) begin
            code_r <= sccrc_pkg::CODE_RESET;
        end else if (shift) begin
            code_r <= code_nxt;
        end
    end
endmodule

/* rtl/sccrc_supply_guard.sv */
// Good-supply persistence timer gating the write circuit
`timescale 1ns/100ps
module sccrc_supply_guard #(
    parameter int GOOD_CYCLES = sccrc_pkg::SUPPLY_GOOD_CYCLES
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic supply_ok,
    output logic      write_enable
);
    logic [26:0] count_r;
    logic        done;

    assign done = (count_r == 27'(GOOD_CYCLES - 1));

    // Any dip restarts the full wait
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_r      <= 27'h000_0000;
            write_enable <= 1'b0;
        end else if (!supply_ok) begin
            count_r      <= 27'h000_0000;
            write_enable <= 1'b0;
        end else if (done) begin
            write_enable <= 1'b1;
        end else begin
            count_r <= count_r + 27'h000_0001;
        end
    end
endmodule
